/* dmc_clock_mode.sv */
// clock source selection, instruction clock and operating mode control
//
// Contract
// RL1: high select bit picks high or low oscillator
// RL2: instruction clock is system clock over 2/4
// RL3: two config words pick high source
// RL4: three config words set internal RC frequency
// RL5: internal RC frees pads; one may output clock
// RL6: crystal modes claim both shared pads
// RL7: one config word picks low source
// RL8: only three source pairings are supported
// RL9: after reset start normal or slow per config
// RL10: normal runs from high, low keeps running
// RL11: select bit write moves between normal and slow
// RL12: mode field enters standby or halt
// RL13: slow keeps high oscillator; stop bit disables
// RL14: firmware enters slow before setting stop
// RL15: low oscillator clocks timer0 when both enabled
// RL16: standby keeps timers; halt wakes externally only
// RL17: standby is 10, halt is 01
// RL18: halt stops both oscillators
// RL19: wake from halt resumes per select bit
// RL20: clock mux switches without runt pulses
`timescale 1ns/1ps
`include "dmc_clock_mode_regs.svh"

module dmc_clock_mode (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic high_freq_osc,
    input wire logic low_freq_osc,
    input wire logic [`DMC_CFG_W-1:0] cfg_words,
    input wire logic wake_external,
    input wire logic wake_timer,
    output logic system_osc,
    output logic instruction_clock,
    output logic high_osc_enable,
    output logic low_osc_enable,
    output logic [2:0] internal_high_rc_freq,
    output logic pads_free_io,
    output logic xtal_pads_claimed,
    output logic clkout_pad_out,
    output logic clkout_pad_oe,
    output logic pairing_error,
    output logic cpu_running,
    output logic timers_enabled,
    output logic timer0_from_low_osc,
    output dmc_pkg::dmc_mode_t op_mode
);
    import dmc_pkg::*;

    typedef struct packed {
        logic hs_s1;
        logic hs_s2;
        logic ls_s1;
        logic ls_s2;
        logic [`DMC_CFG_W-1:0] cfg_s1;
        logic [`DMC_CFG_W-1:0] cfg_s2;
        logic [1:0] wk_s1;
        logic [1:0] wk_s2;
        dmc_phase_t phase;
        logic sel;
        logic stop;
        logic [1:0] opm;
        logic t0low;
        dmc_mode_t mode;
        logic src_hi;
        logic sysclk;
        logic divcnt;
        logic instclk;
        logic dph_wr;
        logic dph_rd;
        logic dph_stat;
        logic dph_osc;
        logic [31:0] rdata;
        logic rdy;
        logic hosc_en;
        logic losc_en;
        logic [2:0] hrc_freq;
        logic pads_free;
        logic xtal;
        logic ck_out;
        logic ck_oe;
        logic perr;
        logic run;
        logic tmr_en;
        logic t0_low;
    } dmc_state_t;

    dmc_state_t st_ff;
    dmc_state_t nxt_st;

    // --------------------------------------------------------------
    // helper decodes
    // --------------------------------------------------------------
    function automatic logic is_reg(input logic [31:0] a, input logic [31:0] off);
        is_reg = (a[31:2] == off[31:2]);
    endfunction

    logic [1:0] hsrc;
    logic ext_hi;
    logic ext_lo;
    logic wr_osc;
    logic [7:0] osc_rd;
    logic target_hi;
    logic sys_rise;
    logic addr_ok;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // two-stage synchronisers for oscillators, config words and wake events
        nxt_st.hs_s1 = high_freq_osc;
        nxt_st.hs_s2 = st_ff.hs_s1;
        nxt_st.ls_s1 = low_freq_osc;
        nxt_st.ls_s2 = st_ff.ls_s1;
        nxt_st.cfg_s1 = cfg_words;
        nxt_st.cfg_s2 = st_ff.cfg_s1;
        nxt_st.wk_s1 = {wake_timer, wake_external};
        nxt_st.wk_s2 = st_ff.wk_s1;

        // source decode from configuration words
        hsrc = st_ff.cfg_s2[`DMC_CFG_HSRC_HI:`DMC_CFG_HSRC_LO]; // [RL3]
        ext_hi = (hsrc == `DMC_HSRC_FAST_XT) || (hsrc == `DMC_HSRC_STD_XT);
        nxt_st.perr = ext_hi && st_ff.cfg_s2[`DMC_CFG_LOW_EXT]; // [RL8]
        // unsupported pairing falls back to the internal low RC
        ext_lo = st_ff.cfg_s2[`DMC_CFG_LOW_EXT] && !ext_hi; // [RL7] [RL8]
        if (st_ff.cfg_s2[`DMC_CFG_HRC_HI:`DMC_CFG_HRC_LO] > `DMC_HRC_MAX) begin
            nxt_st.hrc_freq = `DMC_HRC_MAX; // [RL4]
        end else begin
            nxt_st.hrc_freq = st_ff.cfg_s2[`DMC_CFG_HRC_HI:`DMC_CFG_HRC_LO]; // [RL4]
        end

        // pad sharing
        nxt_st.xtal = ext_hi || ext_lo; // [RL6]
        nxt_st.pads_free = !(ext_hi || ext_lo); // [RL5]
        nxt_st.ck_oe = !(ext_hi || ext_lo) && st_ff.cfg_s2[`DMC_CFG_CLKOUT]; // [RL5]
        nxt_st.ck_out = st_ff.instclk;

        // bus data phase and register write
        wr_osc = st_ff.dph_wr && st_ff.dph_osc;
        if (wr_osc) begin
            nxt_st.sel = hwdata[`DMC_BIT_HIGH_SEL]; // [RL11]
            nxt_st.stop = hwdata[`DMC_BIT_HOSC_STOP]; // [RL13]
            nxt_st.opm = hwdata[`DMC_BIT_OPM_HI:`DMC_BIT_OPM_LO]; // [RL12]
            nxt_st.t0low = hwdata[`DMC_BIT_LOW_T0];
        end

        // start-up: wait for synchronised config then load start clock
        case (st_ff.phase)
            DMC_INIT_A: nxt_st.phase = DMC_INIT_B;
            // second synchroniser stage takes the config word on this edge
            DMC_INIT_B: nxt_st.phase = DMC_INIT_C;
            DMC_INIT_C: begin
                nxt_st.phase = DMC_RUN;
                nxt_st.sel = st_ff.cfg_s2[`DMC_CFG_START_FAST]; // [RL9]
                nxt_st.src_hi = st_ff.cfg_s2[`DMC_CFG_START_FAST];
            end
            DMC_RUN: begin
                case (st_ff.mode)
                    DMC_STANDBY: begin
                        // any timer or external event wakes standby
                        if (|st_ff.wk_s2) begin
                            nxt_st.opm = 2'h0;
                            nxt_st.mode = st_ff.sel ? DMC_NORMAL : DMC_SLOW;
                        end
                    end
                    DMC_HALT: begin
                        if (st_ff.wk_s2[0]) begin // [RL16]
                            nxt_st.opm = 2'h0;
                            nxt_st.mode = st_ff.sel ? DMC_NORMAL : DMC_SLOW; // [RL19]
                        end
                    end
                    default: begin
                        if (st_ff.opm == `DMC_OPM_STANDBY) begin
                            nxt_st.mode = DMC_STANDBY; // [RL12] [RL17]
                        end else if (st_ff.opm == `DMC_OPM_HALT) begin
                            nxt_st.mode = DMC_HALT; // [RL12] [RL17]
                        end else begin
                            nxt_st.mode = st_ff.src_hi ? DMC_NORMAL : DMC_SLOW; // [RL10] [RL11]
                        end
                    end
                endcase
            end
            default: nxt_st.phase = DMC_INIT_A;
        endcase

        // oscillator enables: halt stops both, stop bit honoured only off high clock
        nxt_st.losc_en = (st_ff.mode != DMC_HALT); // [RL18] [RL10]
        nxt_st.hosc_en = (st_ff.mode != DMC_HALT) && !(st_ff.stop && !st_ff.src_hi); // [RL13] [RL18]

        // glitch-free mux: change source only when both sources sit low
        target_hi = st_ff.sel;
        if (st_ff.src_hi != target_hi && !st_ff.hs_s2 && !st_ff.ls_s2 && !st_ff.sysclk) begin
            nxt_st.src_hi = target_hi; // [RL20] [RL1]
        end
        if (st_ff.mode == DMC_HALT) begin
            nxt_st.sysclk = 1'b0;
        end else begin
            nxt_st.sysclk = st_ff.src_hi ? st_ff.hs_s2 : st_ff.ls_s2; // [RL1]
        end

        // instruction clock divider
        sys_rise = nxt_st.sysclk && !st_ff.sysclk;
        if (sys_rise) begin
            nxt_st.divcnt = !st_ff.divcnt;
            if (!st_ff.cfg_s2[`DMC_CFG_DIV4] || st_ff.divcnt) begin
                nxt_st.instclk = !st_ff.instclk; // [RL2]
            end
        end

        // mode-derived outputs
        nxt_st.run = (st_ff.mode == DMC_NORMAL) || (st_ff.mode == DMC_SLOW);
        nxt_st.tmr_en = (st_ff.mode != DMC_HALT); // [RL16]
        nxt_st.t0_low = (st_ff.mode == DMC_NORMAL) && st_ff.t0low
            && st_ff.cfg_s2[`DMC_CFG_T0_LOW]; // [RL15]

        // address phase capture and read data
        addr_ok = hsel && htrans[1] && hready;
        nxt_st.dph_wr = addr_ok && hwrite;
        nxt_st.dph_rd = addr_ok && !hwrite;
        nxt_st.dph_osc = is_reg(haddr, `DMC_OFF_OSC_MODE);
        nxt_st.dph_stat = is_reg(haddr, `DMC_OFF_STATUS);
        nxt_st.rdy = 1'b1;
        osc_rd = {3'h0, nxt_st.t0low, nxt_st.opm, nxt_st.stop, nxt_st.sel};
        nxt_st.rdata = 32'h0000_0000;
        if (addr_ok && !hwrite && is_reg(haddr, `DMC_OFF_OSC_MODE)) begin
            nxt_st.rdata = {24'h00_0000, osc_rd};
        end else if (addr_ok && !hwrite && is_reg(haddr, `DMC_OFF_STATUS)) begin
            nxt_st.rdata = {24'h00_0000, st_ff.perr, st_ff.xtal, st_ff.hosc_en,
                st_ff.losc_en, st_ff.src_hi, st_ff.instclk, st_ff.mode};
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
            st_ff.rdy <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign hrdata = st_ff.rdata;
    assign hreadyout = st_ff.rdy;
    assign hresp = 1'b0 & st_ff.rdy;
    assign system_osc = st_ff.sysclk;
    assign instruction_clock = st_ff.instclk;
    assign high_osc_enable = st_ff.hosc_en;
    assign low_osc_enable = st_ff.losc_en;
    assign internal_high_rc_freq = st_ff.hrc_freq;
    assign pads_free_io = st_ff.pads_free;
    assign xtal_pads_claimed = st_ff.xtal;
    assign clkout_pad_out = st_ff.ck_out;
    assign clkout_pad_oe = st_ff.ck_oe;
    assign pairing_error = st_ff.perr;
    assign cpu_running = st_ff.run;
    assign timers_enabled = st_ff.tmr_en;
    assign timer0_from_low_osc = st_ff.t0_low;
    assign op_mode = st_ff.mode;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking dmc_cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_halt_stops_osc: assert property (st_ff.mode == DMC_HALT |=> // [RL18]
        !high_osc_enable && !low_osc_enable) else $error("oscillator left on in halt");
    a_mode_standby_entry: assert property (st_ff.phase == DMC_RUN // [RL17]
        && (st_ff.mode == DMC_NORMAL || st_ff.mode == DMC_SLOW) && st_ff.opm == 2'h2
        |=> op_mode == DMC_STANDBY) else $error("standby not entered");
    a_mode_halt_entry: assert property (st_ff.phase == DMC_RUN // [RL12]
        && (st_ff.mode == DMC_NORMAL || st_ff.mode == DMC_SLOW) && st_ff.opm == 2'h1
        |=> op_mode == DMC_HALT) else $error("halt not entered");
    a_halt_wake_only_ext: assert property (st_ff.mode == DMC_HALT && !st_ff.wk_s2[0] // [RL16]
        |=> op_mode == DMC_HALT) else $error("halt left without external wake");
    a_wake_sel_mode: assert property (st_ff.mode == DMC_HALT && st_ff.wk_s2[0] // [RL19]
        |=> op_mode == ($past(st_ff.sel) ? DMC_NORMAL : DMC_SLOW)) else $error("bad wake mode");
    a_mux_safe_switch: assert property ($changed(st_ff.src_hi) && st_ff.phase == DMC_RUN // [RL20]
        && $past(st_ff.phase) == DMC_RUN |-> !$past(st_ff.sysclk)) else $error("runt switch");
    a_slow_keeps_hosc: assert property (st_ff.mode == DMC_SLOW && !st_ff.stop // [RL13]
        |=> high_osc_enable) else $error("high oscillator stopped without stop bit");
    a_pads_claimed: assert property (st_ff.xtal |=> !pads_free_io && !clkout_pad_oe) // [RL6]
        else $error("crystal pads used as io");
    a_t0_low_path: assert property (timer0_from_low_osc // [RL15]
        |-> $past(st_ff.mode) == DMC_NORMAL) else $error("timer0 low clock outside normal mode");
    a_start_mode: assert property (st_ff.phase == DMC_INIT_C |=> // [RL9]
        st_ff.sel == $past(st_ff.cfg_s2[`DMC_CFG_START_FAST])) else $error("bad start clock");

    c_enter_slow: cover property (st_ff.mode == DMC_NORMAL ##[1:200] st_ff.mode == DMC_SLOW);
    c_halt_wake: cover property (st_ff.mode == DMC_HALT ##1 st_ff.mode != DMC_HALT);
    c_standby_wake: cover property (st_ff.mode == DMC_STANDBY ##1 st_ff.mode != DMC_STANDBY);
endmodule

/* dmc_clock_mode_regs.svh */
// register offsets, field positions and reset values of the clock and mode control block
`ifndef DMC_CLOCK_MODE_REGS_SVH
`define DMC_CLOCK_MODE_REGS_SVH

// --------------------------------------------------------------
// register map
// --------------------------------------------------------------
`define DMC_OFF_OSC_MODE 32'h0000_0000
`define DMC_OFF_STATUS 32'h0000_0004

// --------------------------------------------------------------
// oscillator_mode_control fields
// --------------------------------------------------------------
`define DMC_BIT_HIGH_SEL 0
`define DMC_BIT_HOSC_STOP 1
`define DMC_BIT_OPM_LO 2
`define DMC_BIT_OPM_HI 3
`define DMC_BIT_LOW_T0 4
`define DMC_OPM_STANDBY 2'h2
`define DMC_OPM_HALT 2'h1
`define DMC_OSC_RESET 8'h00

// --------------------------------------------------------------
// configuration word vector layout
// --------------------------------------------------------------
`define DMC_CFG_W 10
`define DMC_CFG_HSRC_LO 0
`define DMC_CFG_HSRC_HI 1
`define DMC_CFG_HRC_LO 2
`define DMC_CFG_HRC_HI 4
`define DMC_CFG_LOW_EXT 5
`define DMC_CFG_DIV4 6
`define DMC_CFG_START_FAST 7
`define DMC_CFG_CLKOUT 8
`define DMC_CFG_T0_LOW 9
`define DMC_HSRC_INT_RC 2'h0
`define DMC_HSRC_FAST_XT 2'h1
`define DMC_HSRC_STD_XT 2'h2
`define DMC_HRC_MAX 3'h5

`endif

/* dmc_pkg.sv */
// types shared by the clock and mode control block
package dmc_pkg;

    typedef enum logic [1:0] {
        DMC_NORMAL,
        DMC_SLOW,
        DMC_STANDBY,
        DMC_HALT
    } dmc_mode_t;

    typedef enum logic [1:0] {
        DMC_INIT_A,
        DMC_INIT_B,
        DMC_INIT_C,
        DMC_RUN
    } dmc_phase_t;

endpackage

/* tb_dual_clock_mode_control.sv */
// self-checking testbench for the clock and operating mode control block
`timescale 1ns/1ps
`include "dmc_clock_mode_regs.svh"
module tb_dual_clock_mode_control;
    import dmc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, internal_high_rc_freq;
    logic high_freq_osc, low_freq_osc, wake_external, wake_timer;
    logic [`DMC_CFG_W-1:0] cfg_words, c;
    logic system_osc, instruction_clock, high_osc_enable, low_osc_enable, pads_free_io;
    logic xtal_pads_claimed, clkout_pad_out, clkout_pad_oe, pairing_error, cpu_running;
    logic timers_enabled, timer0_from_low_osc, claim;
    dmc_mode_t op_mode;
    int failures = 0, samples_checked = 0, cycles = 0, sys_n, inst_n, ck_n;

    // the single slave's ready closes the bus loop
    assign hready = hreadyout;

    dmc_clock_mode DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .high_freq_osc(high_freq_osc),
        .low_freq_osc(low_freq_osc), .cfg_words(cfg_words), .wake_external(wake_external),
        .wake_timer(wake_timer), .system_osc(system_osc), .instruction_clock(instruction_clock),
        .high_osc_enable(high_osc_enable), .low_osc_enable(low_osc_enable),
        .internal_high_rc_freq(internal_high_rc_freq), .pads_free_io(pads_free_io),
        .xtal_pads_claimed(xtal_pads_claimed), .clkout_pad_out(clkout_pad_out),
        .clkout_pad_oe(clkout_pad_oe), .pairing_error(pairing_error),
        .cpu_running(cpu_running), .timers_enabled(timers_enabled),
        .timer0_from_low_osc(timer0_from_low_osc), .op_mode(op_mode));

    // --------------------------------------------------------------
    // clocks, free-running oscillators, edge counters, timeout
    // --------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // oscillator edges fall on whole ns; every fifth edge of each oscillator lands on an hclk edge
    initial begin
        high_freq_osc = 1'b0;
        forever #30 high_freq_osc = ~high_freq_osc;
    end
    initial begin
        low_freq_osc = 1'b0;
        forever #170 low_freq_osc = ~low_freq_osc;
    end
    always @(posedge system_osc) sys_n++;
    always @(posedge instruction_clock) inst_n++;
    always @(posedge clkout_pad_out) ck_n++;
    // cut a hang short
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    // --------------------------------------------------------------
    // compare, bus and sequencing tasks
    // --------------------------------------------------------------
    task check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task check_range(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    // one single-word transfer: hold address phase, then data phase, until ready
    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // reset with a configuration vector held stable from the start
    task start(input logic [9:0] cw);
        @(posedge hclk);
        hresetn <= 1'b0;
        cfg_words <= cw;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (40) @(posedge hclk);
    endtask
    task wait_mode(input dmc_mode_t m);
        int n;
        n = 0;
        while (op_mode !== m && n < 200) begin
            @(posedge hclk);
            n++;
        end
        check_val({30'h0, op_mode}, {30'h0, m});
        // mode-derived outputs trail the mode by one edge
        @(posedge hclk);
    endtask
    // count oscillator-derived edges over 400 bus cycles
    task rates(input int lo, input int hi, input int div);
        sys_n = 0;
        inst_n = 0;
        ck_n = 0;
        repeat (400) @(posedge hclk);
        check_range(sys_n, lo, hi);
        check_range(inst_n * div, sys_n - div, sys_n + div);
        check_range(ck_n * div, sys_n - 2 * div, sys_n + 2 * div);
    endtask
    task end_of_test();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, wake_external, wake_timer} = 5'h00;
        {haddr, hwdata, htrans, hsize} = 69'h0;
        cfg_words = 10'h080;
        void'($urandom(81));
        start(10'h080);
        wait_mode(DMC_NORMAL);
        rates(160, 173, 2);
        xfer(1'b1, `DMC_OFF_OSC_MODE, 32'h0);
        wait_mode(DMC_SLOW);
        check_val(high_osc_enable, 1'b1);
        rates(27, 31, 2);
        xfer(1'b1, `DMC_OFF_OSC_MODE, 32'h2);
        repeat (6) @(posedge hclk);
        check_val(high_osc_enable, 1'b0);
        xfer(1'b1, `DMC_OFF_OSC_MODE, 32'h11);
        wait_mode(DMC_NORMAL);
        check_val({high_osc_enable, low_osc_enable}, 2'h3);
        check_val(timer0_from_low_osc, 1'b0);
        $display("test mode switching done");
        // standby, left by a timer wake, field cleared
        xfer(1'b1, `DMC_OFF_OSC_MODE, 32'h9);
        wait_mode(DMC_STANDBY);
        check_val({cpu_running, timers_enabled}, 2'h1);
        wake_timer <= 1'b1;
        wait_mode(DMC_NORMAL);
        wake_timer <= 1'b0;
        xfer(1'b0, `DMC_OFF_OSC_MODE, 32'h0);
        check_val(rd, 32'h1);
        // halt from slow: timer wake ignored, external wake returns to slow
        xfer(1'b1, `DMC_OFF_OSC_MODE, 32'h0);
        wait_mode(DMC_SLOW);
        xfer(1'b1, `DMC_OFF_OSC_MODE, 32'h4);
        wait_mode(DMC_HALT);
        check_val({high_osc_enable, low_osc_enable, timers_enabled}, 3'h0);
        wake_timer <= 1'b1;
        repeat (10) @(posedge hclk);
        check_val({30'h0, op_mode}, {30'h0, DMC_HALT});
        wake_timer <= 1'b0;
        wake_external <= 1'b1;
        wait_mode(DMC_SLOW);
        wake_external <= 1'b0;
        $display("test standby and halt done");
        // unmapped address reads zero and ignores writes
        xfer(1'b1, 32'h0000_0008, 32'hFFFF_FFFF);
        xfer(1'b0, 32'h0000_0008, 32'h0);
        check_val(rd, 32'h0);
        xfer(1'b0, `DMC_OFF_OSC_MODE, 32'h0);
        check_val(rd, 32'h0);
        $display("test unmapped access done");
        // divide by four and low clock to timer0
        start(10'h2C0);
        rates(160, 173, 4);
        xfer(1'b1, `DMC_OFF_OSC_MODE, 32'h11);
        repeat (6) @(posedge hclk);
        check_val(timer0_from_low_osc, 1'b1);
        $display("test divider and timer0 source done");
        // configuration sweep: corners then random vectors
        for (int i = 0; i < 10; i++) begin
            c = 10'($urandom);
            c[1:0] = (i < 3) ? 2'(i) : 2'($urandom % 3);
            if (i == 3) c[5:0] = 6'h21;
            start(c);
            claim = (c[1:0] != 2'h0) || c[5];
            check_val({xtal_pads_claimed, pads_free_io}, {claim, !claim});
            check_val(clkout_pad_oe, !claim && c[8]);
            check_val(pairing_error, (c[1:0] != 2'h0) && c[5]);
            check_val(hresp, 1'b0);
            if (c[1:0] == 2'h0) begin
                check_val(internal_high_rc_freq, (c[4:2] > 3'h5) ? 3'h5 : c[4:2]);
            end
            wait_mode(c[7] ? DMC_NORMAL : DMC_SLOW);
            xfer(1'b0, `DMC_OFF_STATUS, 32'h0);
            check_val(rd & 32'hC0, {24'h0, (c[1:0] != 2'h0) && c[5], claim, 6'h0});
            xfer(1'b0, `DMC_OFF_OSC_MODE, 32'h0);
            check_val(rd, {31'h0, c[7]});
        end
        $display("test configuration sweep done");
        end_of_test();
    end
endmodule
